// >>> dma_out_pkg.sv
// Package for the DMA bus-master output block: states, widths, reset values.
// Assumes a single 40 MHz clock domain.
package dma_out_pkg;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned SYNC_STAGES = 3;
    localparam logic [3:0] ACK_POL_RST = 4'h0;
    localparam logic [3:0] REQ_POL_RST = 4'hf;
    localparam logic [3:0] MASK_RST = 4'hf;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [1:0] XFER_VERIFY = 2'h0;
    localparam logic [1:0] XFER_WRITE = 2'h1;
    localparam logic [1:0] XFER_READ = 2'h2;
    localparam logic [1:0] XFER_MEM2MEM = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_GRANT,
        ST_IDLE_WAIT,
        ST_ADDR_UPDATE,
        ST_STROBE,
        ST_FINISH
    } cycle_state_e;
endpackage

// >>> req_sync_if.sv
// Carries synchronised, polarity-corrected channel requests between modules.
// Assumes both ends sit on clock_i.
interface req_sync_if;
    logic [3:0] raw;
    logic [3:0] active;
    modport producer (input raw, output active);
    modport consumer (output raw, input active);
endinterface

// >>> req_sync.sv
// Three-stage synchroniser per channel request, with programmable polarity.
// Assumes asynchronous request pins, single clock.
module req_sync
    import dma_out_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [3:0] req_pol_i,
    req_sync_if.producer bus
);
    logic [3:0] s1_q, s2_q, s3_q, act_q;
    logic [3:0] s1_d, s2_d, s3_d, act_d;
    logic [1:0] fill_q, fill_d;
    logic primed;

    // Stages start at zero, which may read as active; ignore them until filled
    always_comb
    begin
        primed = (fill_q == 2'(SYNC_STAGES));
        fill_d = primed ? fill_q : fill_q + 2'h1;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            always_comb
            begin
                s1_d[g] = bus.raw[g];
                s2_d[g] = s1_q[g];
                s3_d[g] = s2_q[g];
                // Change accepted only when stages two and three agree
                act_d[g] = (primed && s2_q[g] == s3_q[g]) ? (s3_q[g] == req_pol_i[g])
                    : act_q[g];
            end
        end
    endgenerate

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
            act_q <= 4'h0;
            fill_q <= 2'h0;
        end
        else if (clk_en_i)
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            act_q <= act_d;
            fill_q <= fill_d;
        end
    end

    assign bus.active = act_q;
endmodule

// >>> chan_pick.sv
// Fixed-priority picker: lowest numbered unmasked pending channel wins.
// Assumes synchronised request levels from req_sync.
module chan_pick
    import dma_out_pkg::*;
(
    input wire logic [3:0] pend_i,
    output logic any_o,
    output logic [1:0] chan_o
);
    always_comb
    begin
        any_o = |pend_i;
        chan_o = 2'h0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (pend_i[i])
            begin
                chan_o = 2'(i);
            end
        end
    end
endmodule

// >>> dma_bus_master_outputs.sv
// Bus-master output side of a four-channel DMA controller: bus hold
// handshake, channel acknowledges, upper address latch control, memory
// strobes and address pins. Assumes the arbiter grants after releasing
// the buses; request pins are asynchronous.
//
// Operation
// - Upper address nibble driven only during active cycle, floated otherwise.
// - Hold request raised on unmasked channel request or software request.
// - Arbiter grants after releasing buses; no transfer before grant seen.
// - Hold request looped to grant gives exactly one idle wait state.
// - Acknowledge polarity programmable; reset makes all acknowledges active low. Reset here only loads all acknowledges high; polarity then follows ack_pol_i.
// - Acknowledge the channel whose peripheral has been granted a cycle.
// - Upper address enable high during transfers to gate external latch.
// - Pulse upper address strobe high so external latch captures upper byte.
// - In block mode strobe and update state only when upper byte changes.
// - Active-low three-state memory read strobe in read and memory-to-memory.
// - Active-low three-state memory write strobe in write and memory-to-memory.
// - Upper address byte placed on data bus during DMA cycles.
// - Lower address nibble driven as outputs during active cycle.
// - Channel request input polarity programmable.
module dma_bus_master_outputs
    import dma_out_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [3:0] channel_request_in_i,
    input wire logic [3:0] req_pol_i,
    input wire logic [3:0] ack_pol_i,
    input wire logic [3:0] mask_i,
    input wire logic [3:0] sw_request_i,
    input wire logic block_mode_i,
    input wire logic [1:0] xfer_type_i,
    input wire logic [ADDR_W-1:0] start_addr_i,
    input wire logic [7:0] block_len_i,
    input wire logic bus_hold_grant_i,
    output logic bus_hold_request_o,
    output logic [3:0] channel_acknowledge_out_o,
    output logic upper_address_enable_o,
    output logic upper_address_strobe_o,
    output logic memory_read_strobe_n_o,
    output logic memory_read_oe_n_o,
    output logic memory_write_strobe_n_o,
    output logic memory_write_oe_n_o,
    output logic [3:0] address_upper_nibble_o,
    output logic address_upper_oe_n_o,
    output logic [3:0] address_lower_nibble_o,
    output logic address_lower_oe_n_o,
    output logic [7:0] bidirectional_data_bus_o,
    output logic bidirectional_data_bus_oe_n_o,
    output logic busy_o
);
    req_sync_if rq ();

    logic [3:0] pend;
    logic any_pend;
    logic [1:0] pick;

    req_sync u_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .req_pol_i(req_pol_i),
        .bus(rq.producer)
    );
    assign rq.raw = channel_request_in_i;

    // Software requests ignore the mask
    assign pend = (rq.active & ~mask_i) | sw_request_i;

    chan_pick u_pick (
        .pend_i(pend),
        .any_o(any_pend),
        .chan_o(pick)
    );

    cycle_state_e st_q, st_d;
    logic [1:0] ch_q, ch_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] left_q, left_d;
    logic first_q, first_d;
    logic hrq_q, hrq_d;
    logic [3:0] ack_q, ack_d;
    logic aen_q, aen_d;
    logic stb_q, stb_d;
    logic rd_n_q, rd_n_d, wr_n_q, wr_n_d;
    logic drv_q, drv_d;
    logic [7:0] db_q, db_d;
    logic [ADDR_W-1:0] next_addr;
    logic [3:0] ack_active;

    assign next_addr = addr_q + 16'h0001;

    always_comb
    begin
        st_d = st_q;
        ch_d = ch_q;
        addr_d = addr_q;
        left_d = left_q;
        first_d = first_q;
        hrq_d = hrq_q;
        ack_active = 4'h0;
        stb_d = 1'b0;
        rd_n_d = 1'b1;
        wr_n_d = 1'b1;
        aen_d = 1'b0;
        drv_d = 1'b0;
        db_d = db_q;
        unique case (st_q)
            ST_IDLE:
            begin
                if (any_pend)
                begin
                    hrq_d = 1'b1;
                    ch_d = pick;
                    st_d = ST_WAIT_GRANT;
                end
            end
            ST_WAIT_GRANT:
            begin
                // Grant sampled after our own request; looped-back grant
                // therefore costs exactly one idle wait cycle.
                if (bus_hold_grant_i && hrq_q)
                begin
                    st_d = ST_IDLE_WAIT;
                end
            end
            ST_IDLE_WAIT:
            begin
                addr_d = start_addr_i;
                left_d = block_mode_i ? block_len_i : 8'h00;
                first_d = 1'b1;
                st_d = ST_ADDR_UPDATE;
            end
            ST_ADDR_UPDATE:
            begin
                aen_d = 1'b1;
                drv_d = 1'b1;
                stb_d = 1'b1;
                db_d = addr_q[15:8];
                ack_active[ch_q] = 1'b1;
                first_d = 1'b0;
                st_d = ST_STROBE;
            end
            ST_STROBE:
            begin
                aen_d = 1'b1;
                drv_d = 1'b1;
                ack_active[ch_q] = 1'b1;
                rd_n_d = ~(xfer_type_i == XFER_READ || xfer_type_i == XFER_MEM2MEM);
                wr_n_d = ~(xfer_type_i == XFER_WRITE || xfer_type_i == XFER_MEM2MEM);
                if (left_q != 8'h00 && bus_hold_grant_i)
                begin
                    left_d = left_q - 8'h01;
                    addr_d = next_addr;
                    // Skip the update state while the upper byte holds
                    if (next_addr[15:8] != addr_q[15:8])
                    begin
                        st_d = ST_ADDR_UPDATE;
                    end
                end
                else
                begin
                    st_d = ST_FINISH;
                end
            end
            ST_FINISH:
            begin
                ch_d = pick;
                if (any_pend)
                begin
                    st_d = ST_WAIT_GRANT;
                end
                else
                begin
                    hrq_d = 1'b0;
                    st_d = ST_IDLE;
                end
            end
        endcase
        // Never acknowledge without the grant in hand
        if (!bus_hold_grant_i)
        begin
            ack_active = 4'h0;
        end
        ack_d = ~(ack_active ^ ack_pol_i);
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= ST_IDLE;
            ch_q <= 2'h0;
            addr_q <= ADDR_RST;
            left_q <= 8'h00;
            first_q <= 1'b0;
            hrq_q <= 1'b0;
            ack_q <= ~ACK_POL_RST;
            aen_q <= 1'b0;
            stb_q <= 1'b0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            drv_q <= 1'b0;
            db_q <= 8'h00;
        end
        else if (clk_en_i)
        begin
            st_q <= st_d;
            ch_q <= ch_d;
            addr_q <= addr_d;
            left_q <= left_d;
            first_q <= first_d;
            hrq_q <= hrq_d;
            ack_q <= ack_d;
            aen_q <= aen_d;
            stb_q <= stb_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            drv_q <= drv_d;
            db_q <= db_d;
        end
    end

    // Address pins are registered from addr_d, so they track addr_q in step with drv_q;
    // the strobes are registered on the same edge.
    logic [3:0] up_q, lo_q;
    // Enables kept in their own flops so every pin comes straight from a register
    logic oe_n_q, db_oe_n_q;
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            up_q <= 4'h0;
            lo_q <= 4'h0;
            oe_n_q <= 1'b1;
            db_oe_n_q <= 1'b1;
        end
        else if (clk_en_i)
        begin
            up_q <= addr_d[7:4];
            lo_q <= addr_d[3:0];
            oe_n_q <= ~drv_d;
            db_oe_n_q <= ~stb_d;
        end
    end

    assign bus_hold_request_o = hrq_q;
    assign channel_acknowledge_out_o = ack_q;
    assign upper_address_enable_o = aen_q;
    assign upper_address_strobe_o = stb_q;
    assign memory_read_strobe_n_o = rd_n_q;
    assign memory_read_oe_n_o = oe_n_q;
    assign memory_write_strobe_n_o = wr_n_q;
    assign memory_write_oe_n_o = oe_n_q;
    assign address_upper_nibble_o = up_q;
    assign address_upper_oe_n_o = oe_n_q;
    assign address_lower_nibble_o = lo_q;
    assign address_lower_oe_n_o = oe_n_q;
    assign bidirectional_data_bus_o = db_q;
    assign bidirectional_data_bus_oe_n_o = db_oe_n_q;
    assign busy_o = hrq_q;
endmodule

// >>> dma_bus_master_outputs_sva.sv
// Checker for the DMA bus-master output block.
// Assumes it is bound onto the block's top module.
module dma_bus_master_outputs_sva (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] ack_pol_i,
    input wire logic [3:0] sw_request_i,
    input wire logic [1:0] xfer_type_i,
    input wire logic bus_hold_grant_i,
    input wire logic bus_hold_request_o,
    input wire logic [3:0] channel_acknowledge_out_o,
    input wire logic upper_address_enable_o,
    input wire logic upper_address_strobe_o,
    input wire logic memory_read_strobe_n_o,
    input wire logic memory_read_oe_n_o,
    input wire logic memory_write_strobe_n_o,
    input wire logic memory_write_oe_n_o,
    input wire logic address_upper_oe_n_o,
    input wire logic busy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Acks lag a polarity change by a cycle
    property p_ack_off;
        !bus_hold_grant_i [*2] ##0 $stable(ack_pol_i) |-> channel_acknowledge_out_o == ~ack_pol_i;
    endproperty
    a_ack_off: assert property (p_ack_off) else $error("ack without grant");
    property p_one_ack;
        $stable(ack_pol_i) |-> $onehot0(channel_acknowledge_out_o ^ ~ack_pol_i);
    endproperty
    a_one_ack: assert property (p_one_ack) else $error("two acks");
    property p_grant;
        $rose(upper_address_enable_o) |-> $past(bus_hold_grant_i) && bus_hold_request_o;
    endproperty
    a_grant: assert property (p_grant) else $error("transfer before grant");
    property p_wait;
        $rose(bus_hold_grant_i) |-> !upper_address_enable_o ##1 !upper_address_enable_o
            ##[1:2] upper_address_enable_o;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state count");
    property p_stb;
        upper_address_strobe_o |-> upper_address_enable_o ##1 !upper_address_strobe_o;
    endproperty
    a_stb: assert property (p_stb) else $error("strobe not a pulse");
    property p_rd;
        !memory_read_strobe_n_o |-> !memory_read_oe_n_o && xfer_type_i[1];
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe misuse");
    property p_wr;
        !memory_write_strobe_n_o |-> !memory_write_oe_n_o && xfer_type_i[0];
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe misuse");
    property p_float;
        !address_upper_oe_n_o |-> busy_o || $past(busy_o);
    endproperty
    a_float: assert property (p_float) else $error("address driven idle");
    property p_raise;
        sw_request_i != 4'h0 && !busy_o |-> ##[1:2] bus_hold_request_o;
    endproperty
    a_raise: assert property (p_raise) else $error("no hold request");
    property p_drop;
        $fell(bus_hold_request_o) |-> sw_request_i == 4'h0;
    endproperty
    a_drop: assert property (p_drop) else $error("hold dropped early");
endmodule
bind dma_bus_master_outputs dma_bus_master_outputs_sva u_sva (.*);

// >>> bus_arbiter_model.sv
// Arbiter model: grants the hold a set number of cycles after the request.
// Assumes delay 0 means the request is looped straight to the grant.
module bus_arbiter_model (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic hold_req_i,
    input wire logic [3:0] delay_i,
    output logic hold_grant_o
);
    logic [3:0] cnt_q;
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i || !hold_req_i)
            cnt_q <= 4'h0;
        else if (cnt_q != delay_i)
            cnt_q <= cnt_q + 4'h1;
    end
    // Grant only once buses are free; withdrawn with the request
    assign hold_grant_o = hold_req_i && cnt_q == delay_i;
endmodule

// >>> dma_bus_master_outputs_tb.sv
// Bench for the DMA bus-master output block.
// Assumes the arbiter model and the bound checker.
module dma_bus_master_outputs_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
$display("unexpected %s exp %h got %h", n, e, s); end end
    typedef struct packed {logic [3:0] ack; logic [15:0] adr; logic rd; logic wr;} note_s;
    note_s exp_q[$];
    note_s got = '0;
    int seed = 20, fail_count = 0, num_checks = 0, cyc = 0, nstb = 0, nrd = 0;
    logic act = 0, clock_i = 0, sys_rst_i = 1, clk_en_i = 1, block_mode_i = 0;
    logic bus_hold_grant_i, bus_hold_request_o, upper_address_enable_o, busy_o;
    logic upper_address_strobe_o, memory_read_strobe_n_o, memory_read_oe_n_o;
    logic memory_write_strobe_n_o, memory_write_oe_n_o, address_upper_oe_n_o;
    logic address_lower_oe_n_o, bidirectional_data_bus_oe_n_o;
    logic [3:0] channel_request_in_i = 4'hf, req_pol_i = 4'h0, ack_pol_i = 4'h0;
    logic [3:0] mask_i = 4'hf, sw_request_i = 4'h0, dly = 4'h0;
    logic [3:0] channel_acknowledge_out_o, address_upper_nibble_o, address_lower_nibble_o;
    logic [1:0] xfer_type_i = 2'h0;
    logic [15:0] start_addr_i = 16'h0000;
    logic [7:0] block_len_i = 8'h00, bidirectional_data_bus_o;
    dma_bus_master_outputs u_dut (.*);
    bus_arbiter_model u_arb (.clock_i, .sys_rst_i, .hold_req_i(bus_hold_request_o),
        .delay_i(dly), .hold_grant_o(bus_hold_grant_i));
    always #12.5 clock_i = ~clock_i;
    // Pins switch with the enable; judge once every driver has let go
    always @(negedge clock_i)
    begin
        nstb += upper_address_strobe_o;
        nrd += !memory_read_strobe_n_o;
        act |= upper_address_enable_o && !block_mode_i;
        if (!bidirectional_data_bus_oe_n_o) got.adr[15:8] = bidirectional_data_bus_o;
        if (!address_upper_oe_n_o) got.adr[7:4] = address_upper_nibble_o;
        if (!address_lower_oe_n_o) got.adr[3:0] = address_lower_nibble_o;
        if (upper_address_enable_o) got.ack = channel_acknowledge_out_o;
        got.rd |= !memory_read_strobe_n_o;
        got.wr |= !memory_write_strobe_n_o;
        if (act && !upper_address_enable_o && &{address_lower_oe_n_o, address_upper_oe_n_o,
            bidirectional_data_bus_oe_n_o, memory_read_oe_n_o, memory_write_oe_n_o})
        begin
            act = 0;
            `CHK("spare", 1'b1, exp_q.size() > 0)
            if (exp_q.size() > 0)
            begin
                `CHK("ack", exp_q[0].ack, got.ack)
                `CHK("addr", exp_q[0].adr, got.adr)
                `CHK("read", exp_q[0].rd, got.rd)
                `CHK("write", exp_q[0].wr, got.wr)
                void'(exp_q.pop_front());
            end
            got = '0;
        end
    end
    task automatic serve(input int ch, input logic pin);
        logic [3:0] b;
        b = 4'h1 << ch;
        start_addr_i = 16'($random(seed));
        ack_pol_i = 4'($random(seed));
        exp_q.push_back({~ack_pol_i ^ b, start_addr_i, xfer_type_i});
        if (pin) channel_request_in_i = ~b;
        else sw_request_i = b;
        while (!busy_o) @(negedge clock_i);
        // Released early so the synchroniser clears before the finish state
        channel_request_in_i = 4'hf;
        while (!upper_address_enable_o) @(negedge clock_i);
        sw_request_i = 4'h0;
        while (busy_o) @(negedge clock_i);
        repeat (6) @(negedge clock_i);
        $display("service on channel %0d done", ch);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        repeat (10) @(negedge clock_i);
        sys_rst_i = 0;
        `CHK("ack", 4'hf, channel_acknowledge_out_o)
        `CHK("oe", 2'h3, {address_upper_oe_n_o, address_lower_oe_n_o})
        mask_i = 4'h0;
        repeat (8) @(negedge clock_i);
        `CHK("idle", 1'b0, busy_o)
        $display("reset test done");
        for (int t = 0; t < 4; t++)
        begin
            xfer_type_i = 2'(t);
            dly = 4'(t * 3);
            serve(t, 0);
        end
        mask_i = 4'h4;
        channel_request_in_i = 4'hb;
        repeat (8) @(negedge clock_i);
        `CHK("masked", 1'b0, busy_o)
        channel_request_in_i = 4'hf;
        repeat (6) @(negedge clock_i);
        mask_i = 4'h0;
        serve(2, 1);
        serve(3, 1);
        block_mode_i = 1;
        xfer_type_i = 2'h2;
        dly = 4'h0;
        start_addr_i = 16'h12fe;
        block_len_i = 8'h03;
        nstb = 0;
        nrd = 0;
        sw_request_i = 4'h2;
        while (!upper_address_enable_o) @(negedge clock_i);
        sw_request_i = 4'h0;
        while (busy_o) @(negedge clock_i);
        repeat (4) @(negedge clock_i);
        `CHK("strobes", 2, nstb)
        `CHK("reads", 4, nrd)
        $display("block test done");
        test_done();
    end
endmodule
